// ### pkg/usbdb_defs.svh
// usbdb_defs.svh - offsets, field positions and reset values of the block.
// definitions only; included by bare name.
// Contract
// - busy endpoint answers a new transaction with NAK
// - peripheral buffer follows active direction toggle bit
// - other direction toggle bit is software buffer flag
// - flag zero selects pair 0, one pair 1
// - equal flags give effective NAK, programmed status kept
// - double-buffer flow control starts after first transaction
// - completion sets complete flag, toggles direction bit
// - double-buffered completions after the first leave programmed status alone
// - programmed status other than valid overrides flags
// - status codes: 00 off, 01 stall, 10 nak, 11 valid
`ifndef USBDB_DEFS_SVH
`define USBDB_DEFS_SVH

// apb register offsets (byte addresses)
`define USBDB_OFF_EPCTL 8'h00
`define USBDB_OFF_IRQ_STAT 8'h04
`define USBDB_OFF_IRQ_MASK 8'h08
`define USBDB_OFF_STATE 8'h0c

// endpoint register field positions
`define USBDB_BIT_RX_TRANSFER_COMPLETE 15
`define USBDB_BIT_RX_TOG 14
`define USBDB_LSB_STAT_RX 12
`define USBDB_LSB_ENDPOINT_TYPE_FIELD 9
`define USBDB_BIT_ENDPOINT_KIND_BIT 8
`define USBDB_BIT_TX_TRANSFER_COMPLETE 7
`define USBDB_BIT_TX_TOG 6
`define USBDB_LSB_STAT_TX 4

// state register field positions
`define USBDB_LSB_EFF_RX 0
`define USBDB_LSB_EFF_TX 2
`define USBDB_BIT_ARMED 4
`define USBDB_BIT_BUSY 5
`define USBDB_BIT_BUFSEL 6

// interrupt bit positions and width
`define USBDB_IRQ_W 2
`define USBDB_IRQ_RX 0
`define USBDB_IRQ_TX 1

// reset values
`define USBDB_RST_STAT 2'h0
`define USBDB_RST_TYPE 2'h0
`define USBDB_RST_BIT 1'b0
`define USBDB_RST_WORD 32'h0000_0000

`endif

// ### pkg/usbdb_pkg.sv
// usbdb_pkg - types of the double-buffered bulk endpoint block.
// assumes the defs header holds the numeric constants.
`default_nettype none
package usbdb_pkg;
    // endpoint status pair encodings
    typedef enum logic [1:0]
    {
        STAT_DISABLED = 2'h0,
        STAT_STALL = 2'h1,
        STAT_NAK = 2'h2,
        STAT_VALID = 2'h3
    } usbdb_stat_e;

    // endpoint type field encodings
    typedef enum logic [1:0]
    {
        TYPE_BULK = 2'h0,
        TYPE_CONTROL = 2'h1,
        TYPE_ISO = 2'h2,
        TYPE_INTR = 2'h3
    } usbdb_type_e;

    // transaction engine state, one-hot
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'h1,
        ST_BUSY = 2'h2
    } usbdb_state_e;
endpackage
`default_nettype wire

// ### rtl/usbdb_toggle_bit.sv
// usbdb_toggle_bit - one toggle-only flag bit.
// assumes both flip requests are single-cycle pulses on i_mclk.
`include "usbdb_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module usbdb_toggle_bit
    import usbdb_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_sw_flip,
    input wire logic i_hw_flip,
    output var logic o_q
);
    //////////////////////////////////////////////////////////////////////
    // flag can only be flipped, never loaded, so software init is by toggle
    // same-cycle sw and hw flips both apply and cancel
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_q <= `USBDB_RST_BIT;
        end
        else
        begin
            o_q <= o_q ^ i_sw_flip ^ i_hw_flip;
        end
    end
endmodule
`default_nettype wire

// ### rtl/usbdb_irq_status.sv
// usbdb_irq_status - sticky event bits, mask and level interrupt.
// assumes event pulses and write strobes come from the i_mclk domain.
`include "usbdb_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module usbdb_irq_status
    import usbdb_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic [`USBDB_IRQ_W-1:0] i_set,
    input wire logic i_clr_we,
    input wire logic i_mask_we,
    input wire logic [`USBDB_IRQ_W-1:0] i_wdata,
    output var logic [`USBDB_IRQ_W-1:0] o_status,
    output var logic [`USBDB_IRQ_W-1:0] o_mask,
    output var logic o_irq
);
    logic [`USBDB_IRQ_W-1:0] nxt_status; // status after set and clear

    //////////////////////////////////////////////////////////////////////
    // per-bit sticky flags; a set in the clearing cycle wins
    genvar gi;
    generate
        for (gi = 0; gi < `USBDB_IRQ_W; gi = gi + 1)
        begin : g_bit
            assign nxt_status[gi] = i_set[gi] |
                (o_status[gi] & ~(i_clr_we & i_wdata[gi]));
            always_ff @(posedge i_mclk or posedge i_rst)
            begin
                if (i_rst)
                begin
                    o_status[gi] <= `USBDB_RST_BIT;
                end
                else
                begin
                    o_status[gi] <= nxt_status[gi];
                end
            end
        end
    endgenerate

    // mask register, plain read/write
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_mask <= '0;
        end
        else if (i_mask_we)
        begin
            o_mask <= i_wdata;
        end
    end

    // registered level interrupt, in step with the flags
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_irq <= `USBDB_RST_BIT;
        end
        else
        begin
            o_irq <= |(nxt_status & o_mask);
        end
    end
endmodule
`default_nettype wire

// ### rtl/usbdb_bulk_ctrl.sv
// usbdb_bulk_ctrl - flow control and buffer swap of one bulk endpoint with
// optional double buffering, apb register slave and completion interrupt.
// assumes the protocol engine is on i_mclk and gives one-cycle pulses.
`include "usbdb_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module usbdb_bulk_ctrl
    import usbdb_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output var logic [31:0] o_prdata,
    output var logic o_pready,
    output var logic o_pslverr,
    // protocol engine side
    input wire logic i_tok_valid,
    input wire logic i_tok_tx,
    input wire logic i_txn_end,
    input wire logic i_txn_ok,
    output var logic o_hs_valid,
    output var logic [1:0] o_hs_code,
    output var logic o_xfer_active,
    output var logic o_buf_sel,
    // interrupt
    output var logic o_irq
);
    //////////////////////////////////////////////////////////////////////
    // declarations

    usbdb_stat_e stat_rx_ff; // programmed reception status
    usbdb_stat_e stat_tx_ff; // programmed transmission status
    usbdb_type_e type_ff; // endpoint type field
    logic kind_ff; // endpoint kind bit, double buffer enable on bulk
    logic armed_ff; // double-buffer flow control active
    usbdb_state_e state_ff; // transaction engine state
    logic cur_tx_ff; // direction of the running transaction
    logic [1:0] tog; // [0] rx data toggle, [1] tx data toggle
    logic [1:0] sw_flip; // software toggle strobes
    logic [1:0] hw_flip; // hardware toggle strobes
    logic [`USBDB_IRQ_W-1:0] irq_stat; // sticky completion flags
    logic [`USBDB_IRQ_W-1:0] irq_mask; // interrupt mask
    logic [`USBDB_IRQ_W-1:0] irq_set; // completion pulses
    logic double_buffer_enable; // bulk type and kind bit set
    logic dir_is_tx; // double-buffered direction is transmission
    logic hw_flag; // peripheral buffer flag
    logic software_buffer_flag; // application buffer flag
    logic conflict; // both flags name the same buffer
    usbdb_stat_e eff_rx; // effective reception status
    usbdb_stat_e eff_tx; // effective transmission status
    usbdb_stat_e tok_stat; // effective status of the token direction
    logic tok_flag; // buffer flag for the token direction
    logic setup_ph; // apb setup cycle
    logic wr_acc; // apb write taking effect
    logic [3:0] wr_hit; // write decode per register
    logic done_ok; // transaction finished with success
    logic [31:0] nxt_prdata; // read word captured at setup
    logic [31:0] ep_word; // endpoint register image
    logic [31:0] state_word; // state register image

    //////////////////////////////////////////////////////////////////////
    // functions

    // register decode; bit order epctl, irq_stat, irq_mask, state
    function automatic logic [3:0] reg_dec(input logic [7:0] addr);
        reg_dec = 4'h0;
        unique case (addr)
            `USBDB_OFF_EPCTL: reg_dec = 4'h1;
            `USBDB_OFF_IRQ_STAT: reg_dec = 4'h2;
            `USBDB_OFF_IRQ_MASK: reg_dec = 4'h4;
            `USBDB_OFF_STATE: reg_dec = 4'h8;
            default: reg_dec = 4'h0;
        endcase
    endfunction

    // effective status; only a valid programmed status can be masked to nak
    function automatic usbdb_stat_e eff_stat(input usbdb_stat_e prog,
                                             input logic dbl_dir,
                                             input logic armed,
                                             input logic clash);
        if (armed && dbl_dir && (prog == STAT_VALID) && clash)
        begin
            eff_stat = STAT_NAK;
        end
        else
        begin
            eff_stat = prog;
        end
    endfunction

    //////////////////////////////////////////////////////////////////////
    // buffer flag selection

    // bulk type plus kind bit turns double buffering on
    assign double_buffer_enable = (type_ff == TYPE_BULK) & kind_ff;
    // only one direction is enabled, the non-disabled tx pair picks tx
    assign dir_is_tx = (stat_tx_ff != STAT_DISABLED);
    // active direction toggle is the peripheral flag
    assign hw_flag = dir_is_tx ? tog[1] : tog[0];
    // unused direction toggle is the application flag
    assign software_buffer_flag = dir_is_tx ? tog[0] : tog[1];
    // equal flags mean both want the same buffer pair
    assign conflict = (hw_flag == software_buffer_flag);
    assign eff_rx = eff_stat(stat_rx_ff, double_buffer_enable & ~dir_is_tx,
                             armed_ff, conflict);
    assign eff_tx = eff_stat(stat_tx_ff, double_buffer_enable & dir_is_tx,
                             armed_ff, conflict);
    assign tok_stat = i_tok_tx ? eff_tx : eff_rx;
    // flag value 0 selects pair 0, 1 selects pair 1
    assign tok_flag = i_tok_tx ? tog[1] : tog[0];

    //////////////////////////////////////////////////////////////////////
    // apb decode

    assign setup_ph = i_psel & ~i_penable;
    assign wr_acc = i_psel & i_penable & o_pready & i_pwrite;
    assign wr_hit = wr_acc ? reg_dec(i_paddr) : 4'h0;
    // writing one to a toggle bit flips it, zero leaves it
    assign sw_flip[0] = wr_hit[0] & i_pwdata[`USBDB_BIT_RX_TOG];
    assign sw_flip[1] = wr_hit[0] & i_pwdata[`USBDB_BIT_TX_TOG];

    // endpoint register image
    always_comb
    begin
        ep_word = `USBDB_RST_WORD;
        ep_word[`USBDB_BIT_RX_TRANSFER_COMPLETE] = irq_stat[`USBDB_IRQ_RX];
        ep_word[`USBDB_BIT_RX_TOG] = tog[0];
        ep_word[`USBDB_LSB_STAT_RX +: 2] = stat_rx_ff;
        ep_word[`USBDB_LSB_ENDPOINT_TYPE_FIELD +: 2] = type_ff;
        ep_word[`USBDB_BIT_ENDPOINT_KIND_BIT] = kind_ff;
        ep_word[`USBDB_BIT_TX_TRANSFER_COMPLETE] = irq_stat[`USBDB_IRQ_TX];
        ep_word[`USBDB_BIT_TX_TOG] = tog[1];
        ep_word[`USBDB_LSB_STAT_TX +: 2] = stat_tx_ff;
    end

    // state register image; shows masked status, not programmed one
    always_comb
    begin
        state_word = `USBDB_RST_WORD;
        state_word[`USBDB_LSB_EFF_RX +: 2] = eff_rx;
        state_word[`USBDB_LSB_EFF_TX +: 2] = eff_tx;
        state_word[`USBDB_BIT_ARMED] = armed_ff;
        state_word[`USBDB_BIT_BUSY] = o_xfer_active;
        state_word[`USBDB_BIT_BUFSEL] = o_buf_sel;
    end

    // read mux; unmapped reads return zero
    always_comb
    begin
        nxt_prdata = `USBDB_RST_WORD;
        unique case (reg_dec(i_paddr))
            4'h1: nxt_prdata = ep_word;
            4'h2: nxt_prdata[`USBDB_IRQ_W-1:0] = irq_stat;
            4'h4: nxt_prdata[`USBDB_IRQ_W-1:0] = irq_mask;
            4'h8: nxt_prdata = state_word;
            default: nxt_prdata = `USBDB_RST_WORD;
        endcase
    end

    //////////////////////////////////////////////////////////////////////
    // apb response; ready one cycle after setup so outputs stay registered
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_pready <= `USBDB_RST_BIT;
            o_pslverr <= `USBDB_RST_BIT;
            o_prdata <= `USBDB_RST_WORD;
        end
        else
        begin
            o_pready <= setup_ph;
            // unmapped address answers with an error
            o_pslverr <= setup_ph & (reg_dec(i_paddr) == 4'h0);
            // data sampled at setup; trades a cycle of staleness for no comb path
            o_prdata <= setup_ph ? nxt_prdata : `USBDB_RST_WORD;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // endpoint configuration and programmed status
    assign done_ok = (state_ff == ST_BUSY) & i_txn_end & i_txn_ok;

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            type_ff <= TYPE_BULK;
            kind_ff <= `USBDB_RST_BIT;
        end
        else if (wr_hit[0])
        begin
            type_ff <= usbdb_type_e'(i_pwdata[`USBDB_LSB_ENDPOINT_TYPE_FIELD +: 2]);
            kind_ff <= i_pwdata[`USBDB_BIT_ENDPOINT_KIND_BIT];
        end
    end

    // status pairs; completion in normal flow control forces nak
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            stat_rx_ff <= STAT_DISABLED;
            stat_tx_ff <= STAT_DISABLED;
        end
        else if (done_ok && !armed_ff)
        begin
            // single-buffered or first double-buffered completion
            if (cur_tx_ff)
            begin
                stat_tx_ff <= STAT_NAK;
            end
            else
            begin
                stat_rx_ff <= STAT_NAK;
            end
        end
        else if (wr_hit[0])
        begin
            // armed completions fall here and leave the pair untouched
            stat_rx_ff <= usbdb_stat_e'(i_pwdata[`USBDB_LSB_STAT_RX +: 2]);
            stat_tx_ff <= usbdb_stat_e'(i_pwdata[`USBDB_LSB_STAT_TX +: 2]);
        end
    end

    // special flow control arms at the end of the first transaction
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            armed_ff <= `USBDB_RST_BIT;
        end
        else if (!double_buffer_enable)
        begin
            armed_ff <= `USBDB_RST_BIT; // disarm once enable drops
        end
        else if (done_ok)
        begin
            armed_ff <= 1'b1;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // data toggle bits; hardware flips the completing direction only
    assign hw_flip[0] = done_ok & ~cur_tx_ff;
    assign hw_flip[1] = done_ok & cur_tx_ff;

    genvar gt;
    generate
        for (gt = 0; gt < 2; gt = gt + 1)
        begin : g_tog
            usbdb_toggle_bit u_tog
            (
                .i_mclk(i_mclk),
                .i_rst(i_rst),
                .i_sw_flip(sw_flip[gt]),
                .i_hw_flip(hw_flip[gt]),
                .o_q(tog[gt])
            );
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////
    // transaction engine; a token while busy is refused with nak
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_ff <= ST_IDLE;
            cur_tx_ff <= `USBDB_RST_BIT;
            o_hs_valid <= `USBDB_RST_BIT;
            o_hs_code <= STAT_DISABLED;
            o_xfer_active <= `USBDB_RST_BIT;
            o_buf_sel <= `USBDB_RST_BIT;
        end
        else
        begin
            o_hs_valid <= i_tok_valid;
            unique case (state_ff)
                ST_IDLE:
                begin
                    if (i_tok_valid)
                    begin
                        o_hs_code <= tok_stat;
                        // only a valid effective status starts a transfer
                        if (tok_stat == STAT_VALID)
                        begin
                            state_ff <= ST_BUSY;
                            cur_tx_ff <= i_tok_tx;
                            o_xfer_active <= 1'b1;
                            o_buf_sel <= tok_flag;
                        end
                    end
                end
                ST_BUSY:
                begin
                    if (i_tok_valid)
                    begin
                        o_hs_code <= STAT_NAK;
                    end
                    // failed or successful end both free the engine
                    if (i_txn_end)
                    begin
                        state_ff <= ST_IDLE;
                        o_xfer_active <= `USBDB_RST_BIT;
                    end
                end
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////
    // completion flags and interrupt
    assign irq_set[`USBDB_IRQ_RX] = hw_flip[0];
    assign irq_set[`USBDB_IRQ_TX] = hw_flip[1];

    usbdb_irq_status u_irq
    (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_set(irq_set),
        .i_clr_we(wr_hit[1]),
        .i_mask_we(wr_hit[2]),
        .i_wdata(i_pwdata[`USBDB_IRQ_W-1:0]),
        .o_status(irq_stat),
        .o_mask(irq_mask),
        .o_irq(o_irq)
    );
endmodule
`default_nettype wire

// ### tb/usbdb_bulk_ctrl_properties.sv
// usbdb_bulk_ctrl_properties.sv - port-level checks of the bulk endpoint block.
// assumes one clock and the block's async active-high reset; bound below.
`timescale 1ns/1ps
`default_nettype none
module usbdb_props
    import usbdb_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic i_tok_valid,
    input wire logic i_tok_tx,
    input wire logic i_txn_end,
    input wire logic i_txn_ok,
    input wire logic o_hs_valid,
    input wire logic [1:0] o_hs_code,
    input wire logic o_xfer_active,
    input wire logic o_buf_sel,
    input wire logic o_irq
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    ////////////////////////////////////////////////////////////////
    // token on a busy and on a free engine
    sequence tok_busy;
        i_tok_valid && o_xfer_active && !i_txn_end;
    endsequence
    sequence tok_free;
        i_tok_valid && !o_xfer_active;
    endsequence
    sequence apb_setup;
        i_psel && !i_penable;
    endsequence
    hs_follow_a: assert property (i_tok_valid |=> o_hs_valid)
        else $error("handshake missing after token");
    hs_cause_a: assert property (o_hs_valid |-> $past(i_tok_valid))
        else $error("handshake without token");
    busy_nak_a: assert property (tok_busy |=> o_hs_code == STAT_NAK && o_xfer_active)
        else $error("busy endpoint did not refuse");
    // a transfer starts exactly when the answer is valid
    accept_go_a: assert property (tok_free |=> o_xfer_active == (o_hs_code == STAT_VALID))
        else $error("transfer start disagrees with answer");
    end_free_a: assert property (o_xfer_active && i_txn_end |=> !o_xfer_active)
        else $error("engine not freed at end");
    // a failed end raises no interrupt
    fail_quiet_a: assert property (o_xfer_active && i_txn_end && !i_txn_ok && !o_irq
        && !i_psel |=> !o_irq [*2])
        else $error("failed transfer raised interrupt");
    buf_hold_a: assert property (o_xfer_active && $past(o_xfer_active)
        |-> $stable(o_buf_sel))
        else $error("buffer moved mid transfer");
    code_hold_a: assert property (!o_hs_valid |-> $stable(o_hs_code))
        else $error("answer code changed between tokens");
    apb_ready_a: assert property (apb_setup |=> o_pready ##1 !o_pready)
        else $error("access phase not one cycle");
    rdata_idle_a: assert property (!o_pready |-> o_prdata == 32'h0)
        else $error("read data outside access");
    slverr_pair_a: assert property (o_pslverr |-> o_pready)
        else $error("error without ready");
endmodule
bind usbdb_bulk_ctrl usbdb_props u_props (.i_mclk, .i_rst, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_tok_valid, .i_tok_tx,
    .i_txn_end, .i_txn_ok, .o_hs_valid, .o_hs_code, .o_xfer_active, .o_buf_sel, .o_irq);
`default_nettype wire

// ### tb/usbdb_host_model.sv
// usbdb_host_model.sv - behavioural host issuing bulk tokens and ends.
// assumes the block answers one cycle after a token; caller paces ends.
`timescale 1ns/1ps
`default_nettype none
module usbdb_host_model
(
    input wire logic i_mclk,
    input wire logic i_hs_valid,
    input wire logic [1:0] i_hs_code,
    output var logic o_tok_valid,
    output var logic o_tok_tx,
    output var logic o_txn_end,
    output var logic o_txn_ok
);
    // idle bus at time zero
    initial
    begin
        o_tok_valid = 1'b0;
        o_txn_end = 1'b0;
    end
    // one token; waits as long as the answer takes
    task automatic token(input logic tx, output logic [1:0] code);
        o_tok_valid <= 1'b1;
        o_tok_tx <= tx;
        @(posedge i_mclk);
        o_tok_valid <= 1'b0;
        o_tok_tx <= ~tx; // meaningless between tokens
        do
            @(posedge i_mclk);
        while (i_hs_valid !== 1'b1);
        code = i_hs_code;
    endtask
    // end the running transfer, well or badly
    task automatic finish(input logic ok);
        o_txn_end <= 1'b1;
        o_txn_ok <= ok;
        @(posedge i_mclk);
        o_txn_end <= 1'b0;
        o_txn_ok <= ~ok; // meaningless when idle
    endtask
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// tb_top.sv - self-checking bench of the double-buffered bulk endpoint block.
// assumes the checker binds itself and the host model drives tokens.
`timescale 1ns/1ps
`default_nettype none
`include "usbdb_defs.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
$display("Error %s expected %h seen %h", nm, e, g); end end
module tb_top
    import usbdb_pkg::*;
;
    logic i_mclk, i_rst, i_psel, i_penable, i_pwrite, err;
    logic i_tok_valid, i_tok_tx, i_txn_end, i_txn_ok;
    logic [7:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata, rd;
    logic o_pready, o_pslverr, o_hs_valid, o_xfer_active, o_buf_sel, o_irq;
    logic [1:0] o_hs_code, code;
    int fail_count = 0;
    int check_count = 0;
    usbdb_bulk_ctrl dut (.i_mclk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
        .o_prdata, .o_pready, .o_pslverr, .i_tok_valid, .i_tok_tx, .i_txn_end, .i_txn_ok,
        .o_hs_valid, .o_hs_code, .o_xfer_active, .o_buf_sel, .o_irq);
    usbdb_host_model host (.i_mclk, .i_hs_valid(o_hs_valid), .i_hs_code(o_hs_code),
        .o_tok_valid(i_tok_valid), .o_tok_tx(i_tok_tx), .o_txn_end(i_txn_end),
        .o_txn_ok(i_txn_ok));
    ////////////////////////////////////////////////////////////////
    initial
    begin
        i_mclk = 1'b0;
        forever #2 i_mclk = ~i_mclk;
    end
    task automatic do_reset;
        i_rst <= 1'b1;
        repeat (3) @(posedge i_mclk);
        i_rst <= 1'b0;
        @(posedge i_mclk);
    endtask
    // one apb transfer; waits on pready, never on a fixed count
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_mclk);
        i_penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge i_mclk);
            n++;
        end
        while (o_pready !== 1'b1);
        `CHK("pready wait", 1, n)
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_mclk);
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(nm, e, rd)
    endtask
    task automatic tok(input logic tx, input logic [1:0] e);
        host.token(tx, code);
        `CHK("handshake", e, code)
    endtask
    // endpoint control word, bulk type; toggle flips are write-one
    function automatic logic [31:0] ep(input logic [1:0] srx, input logic k,
        input logic [1:0] stx, input logic frx, input logic ftx);
        return {16'h0, 1'b0, frx, srx, 1'b0, TYPE_BULK, k, 1'b0, ftx, stx, 4'h0};
    endfunction
    task automatic t_regs;
        rdchk("epctl", `USBDB_OFF_EPCTL, 32'h0);
        rdchk("flags", `USBDB_OFF_IRQ_STAT, 32'h0);
        rdchk("mask", `USBDB_OFF_IRQ_MASK, 32'h0);
        rdchk("state", `USBDB_OFF_STATE, 32'h0);
        apb(1'b1, 8'h10, 32'hffff_ffff);
        `CHK("slverr", 1'b1, err)
        rdchk("unmapped", 8'h10, 32'h0);
        `CHK("slverr", 1'b1, err)
        $display("test regs done");
    endtask
    // every code answered, busy refusal, plain completion and interrupt
    task automatic t_single;
        for (int s = 0; s < 4; s++)
        begin
            apb(1'b1, `USBDB_OFF_EPCTL, ep(s[1:0], 1'b0, 2'h0, 1'b0, 1'b0));
            tok(1'b0, s[1:0]);
        end
        tok(1'b0, 2'h2);
        host.finish(1'b1);
        rdchk("epctl", `USBDB_OFF_EPCTL, 32'h0000_e000);
        `CHK("irq", 1'b0, o_irq)
        apb(1'b1, `USBDB_OFF_IRQ_MASK, 32'h1);
        rdchk("flags", `USBDB_OFF_IRQ_STAT, 32'h1);
        `CHK("irq", 1'b1, o_irq)
        apb(1'b1, `USBDB_OFF_IRQ_STAT, 32'h1);
        rdchk("flags", `USBDB_OFF_IRQ_STAT, 32'h0);
        `CHK("irq", 1'b0, o_irq)
        $display("test single done");
    endtask
    // receive side: first end normal, then swap, conflict, release, override
    task automatic t_dbl_rx;
        do_reset();
        apb(1'b1, `USBDB_OFF_IRQ_MASK, 32'h1);
        apb(1'b1, `USBDB_OFF_EPCTL, ep(2'h3, 1'b1, 2'h0, 1'b0, 1'b0));
        tok(1'b0, 2'h3);
        `CHK("bufsel", 1'b0, o_buf_sel)
        host.finish(1'b1);
        rdchk("epctl", `USBDB_OFF_EPCTL, 32'h0000_e100);
        `CHK("irq", 1'b1, o_irq)
        apb(1'b1, `USBDB_OFF_IRQ_STAT, 32'h1);
        apb(1'b1, `USBDB_OFF_EPCTL, ep(2'h3, 1'b1, 2'h0, 1'b0, 1'b0));
        tok(1'b0, 2'h3);
        `CHK("bufsel", 1'b1, o_buf_sel)
        host.finish(1'b1);
        rdchk("epctl", `USBDB_OFF_EPCTL, 32'h0000_b100);
        tok(1'b0, 2'h2);
        apb(1'b0, `USBDB_OFF_STATE, 32'h0);
        `CHK("state", 5'h12, rd[4:0])
        rdchk("epctl", `USBDB_OFF_EPCTL, 32'h0000_b100);
        apb(1'b1, `USBDB_OFF_IRQ_STAT, 32'h1);
        apb(1'b1, `USBDB_OFF_EPCTL, ep(2'h3, 1'b1, 2'h0, 1'b0, 1'b1));
        tok(1'b0, 2'h3);
        `CHK("bufsel", 1'b0, o_buf_sel)
        host.finish(1'b0);
        rdchk("epctl", `USBDB_OFF_EPCTL, 32'h0000_3140);
        `CHK("irq", 1'b0, o_irq)
        for (int s = 0; s < 3; s++)
        begin
            apb(1'b1, `USBDB_OFF_EPCTL, ep(s[1:0], 1'b1, 2'h0, 1'b0, s == 0));
            tok(1'b0, s[1:0]);
        end
        $display("test dbl rx done");
    endtask
    // transmit side: flags swap roles
    task automatic t_dbl_tx;
        do_reset();
        apb(1'b1, `USBDB_OFF_EPCTL, ep(2'h0, 1'b1, 2'h3, 1'b0, 1'b0));
        tok(1'b1, 2'h3);
        host.finish(1'b1);
        rdchk("epctl", `USBDB_OFF_EPCTL, 32'h0000_01e0);
        rdchk("flags", `USBDB_OFF_IRQ_STAT, 32'h2);
        apb(1'b1, `USBDB_OFF_EPCTL, ep(2'h0, 1'b1, 2'h3, 1'b0, 1'b0));
        tok(1'b1, 2'h3);
        `CHK("bufsel", 1'b1, o_buf_sel)
        host.finish(1'b1);
        tok(1'b1, 2'h2);
        apb(1'b1, `USBDB_OFF_EPCTL, ep(2'h0, 1'b1, 2'h3, 1'b1, 1'b0));
        tok(1'b1, 2'h3);
        `CHK("bufsel", 1'b0, o_buf_sel)
        host.finish(1'b1);
        $display("test dbl tx done");
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        i_psel = 1'b0;
        i_penable = 1'b0;
        do_reset();
        t_regs();
        t_single();
        t_dbl_rx();
        t_dbl_tx();
        end_of_test();
    end
    // whole run is about 150 cycles; this only cuts a hang
    initial
    begin
        repeat (5000) @(posedge i_mclk);
        fail_count++;
        $display("Error watchdog expired");
        end_of_test();
    end
endmodule
`default_nettype wire
